/* File: design/epic_pkg.sv */
package epic_pkg;

  // ==========================================================
  // Register map (data-space offsets)
  // ==========================================================
  localparam logic [7:0] ADDR_GROUP_FLAGS = 8'h3b;
  localparam logic [7:0] ADDR_EXT_FLAGS = 8'h3c;
  localparam logic [7:0] ADDR_EXT_MASK = 8'h3d;
  localparam logic [7:0] ADDR_GROUP_ENABLE = 8'h68;
  localparam logic [7:0] ADDR_SENSE = 8'h69;
  localparam logic [7:0] ADDR_MASK_G0 = 8'h6a;
  localparam logic [7:0] ADDR_MASK_G1 = 8'h6b;
  localparam logic [7:0] ADDR_MASK_G2 = 8'h6c;
  localparam logic [7:0] ADDR_MASK_G3 = 8'h6d;
  // I/O instruction view: data-space offset minus this, limited to the I/O range
  localparam logic [7:0] IO_ALIAS_OFFSET = 8'h20;
  localparam logic [7:0] IO_SPACE_MAX = 8'h3f;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] RESET_EXT_FLAGS = 8'h00;
  localparam logic [7:0] RESET_EXT_MASK = 8'h00;
  localparam logic [7:0] RESET_GROUP_ENABLE = 8'h00;
  localparam logic [7:0] RESET_GROUP_FLAGS = 8'h00;
  localparam logic [7:0] RESET_SENSE = 8'h00;
  localparam logic [7:0] RESET_CHANGE_MASK = 8'h00;

  // ==========================================================
  // Sense field encoding and layout
  // ==========================================================
  localparam int SENSE_W = 2;
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // ==========================================================
  // Pin-change group layout and timing
  // ==========================================================
  localparam int G3_MSB = 27;
  localparam int G3_LSB = 24;
  localparam int G2_MSB = 23;
  localparam int G2_LSB = 16;
  localparam int G1_MSB = 14;
  localparam int G1_LSB = 8;
  localparam int G0_MSB = 7;
  localparam int G0_LSB = 0;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int MIN_PULSE_PS = 8000;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [3:0] {
    SEL_NONE, SEL_GROUP_FLAGS, SEL_EXT_FLAGS, SEL_EXT_MASK, SEL_GROUP_ENABLE,
    SEL_SENSE, SEL_MASK_G0, SEL_MASK_G1, SEL_MASK_G2, SEL_MASK_G3
  } epic_reg_e;

  typedef struct packed {
    logic [7:0] addr;
    logic io_space;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } epic_bus_req_s;

endpackage

/* File: design/epic_ctrl.sv */
// Functional notes
// - Sense code per pin: 00 low level, 01 any change, 10 falling, 11 rising.
// - Pin is sampled before edge detection; pulses over one clock are caught.
// - Pin request reaches the CPU only with global enable and its mask bit.
// - Mask register holds one enable per pin, bit n for pin n.
// - Pin activity requests even when the pin is driven as an output.
// - Each external pin has its own vector request line.
// - A matching edge or change sets that pin's flag, bits 3 to 0.
// - Flag clears when the CPU runs the matching vector.
// - Writing one clears a flag; writing zero leaves it.
// - Flag reads zero while its pin is in low-level mode.
// - Four group enables, bits 3 to 0, gated by global enable.
// - Groups: 3 pins 27:24, 2 pins 23:16, 1 pins 14:8, 0 pins 7:0.
// - A pin joins its group only when its own mask bit is set.
// - Each pin-change group has its own vector request line.
// - Flag registers and the external mask register decode at data offset and offset minus 0x20.
// - Mask, flag and group enable registers reset to zero.
// - Pins 3 and 2 use the same sense encoding as pins 1 and 0.
// - Group flag set on enabled change, cleared by vector or write one.
// - Pin-change detection drives wake_o only through logic clocked by clk_i.
`timescale 1ns/1ps
`default_nettype none

module epic_ctrl
  import epic_pkg::*;
#(
  parameter int EXT_PINS = 4,
  parameter int CHANGE_PINS = 28
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire epic_bus_req_s bus_i,
  input wire logic global_irq_enable_i,
  input wire logic [7:0] vec_ack_i,
  input wire logic [3:0] ext_pin_i,
  input wire logic [27:0] change_pin_i,
  output logic [7:0] rdata_o,
  output logic [7:0] irq_req_o,
  output logic wake_o
);

  // ==========================================================
  // Elaboration check
  // ==========================================================
  if (EXT_PINS != 4 || CHANGE_PINS != 28) begin : g_bad_size
    $error("epic_ctrl serves exactly four external and 28 change pins");
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  // Both address views land on one register select
  function automatic epic_reg_e decode(input logic [7:0] addr, input logic io_space);
    logic [7:0] ds;
    ds = addr;
    if (io_space) begin
      ds = (addr <= IO_SPACE_MAX) ? 8'(addr + IO_ALIAS_OFFSET) : 8'h00;
    end
    if (ds == ADDR_GROUP_FLAGS) begin
      return SEL_GROUP_FLAGS;
    end else if (ds == ADDR_EXT_FLAGS) begin
      return SEL_EXT_FLAGS;
    end else if (ds == ADDR_EXT_MASK) begin
      return SEL_EXT_MASK;
    end else if (ds == ADDR_GROUP_ENABLE && !io_space) begin
      return SEL_GROUP_ENABLE;
    end else if (ds == ADDR_SENSE && !io_space) begin
      return SEL_SENSE;
    end else if (ds == ADDR_MASK_G0 && !io_space) begin
      return SEL_MASK_G0;
    end else if (ds == ADDR_MASK_G1 && !io_space) begin
      return SEL_MASK_G1;
    end else if (ds == ADDR_MASK_G2 && !io_space) begin
      return SEL_MASK_G2;
    end else if (ds == ADDR_MASK_G3 && !io_space) begin
      return SEL_MASK_G3;
    end else begin
      return SEL_NONE;
    end
  endfunction

  // Edge/change match for one sense code
  function automatic logic edge_hit(input logic [1:0] code, input logic now, input logic prev);
    case (code)
      SENSE_ANY: return now ^ prev;
      SENSE_FALL: return prev & ~now;
      SENSE_RISE: return now & ~prev;
      default: return 1'b0;
    endcase
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  logic [7:0] sense;
  logic [3:0] ext_mask;
  logic [3:0] ext_flags;
  logic [3:0] group_enable;
  logic [3:0] group_flags;
  logic [7:0] mask_g0;
  logic [6:0] mask_g1;
  logic [7:0] mask_g2;
  logic [3:0] mask_g3;
  logic [3:0] ext_now;
  logic [3:0] ext_prev;
  logic [27:0] chg_now;
  logic [27:0] chg_prev;
  logic sample_valid;
  logic sample_armed;
  logic [3:0] next_ext_flags;
  logic [3:0] next_group_flags;
  logic [3:0] ext_hit;
  logic [3:0] ext_level;
  logic [3:0] group_hit;
  logic [27:0] chg_enable;
  logic [27:0] chg_diff;
  logic [7:0] next_irq_req;
  logic [7:0] next_rdata;
  epic_reg_e sel;
  logic wr_ext_flags;
  logic wr_group_flags;

  assign sel = decode(bus_i.addr, bus_i.io_space);
  assign wr_ext_flags = bus_i.wr && sel == SEL_EXT_FLAGS;
  assign wr_group_flags = bus_i.wr && sel == SEL_GROUP_FLAGS;

  // ==========================================================
  // Pin sampling
  // ==========================================================
  // Pins are sampled even when driven by the port as outputs
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ext_now <= 4'h0;
      ext_prev <= 4'h0;
      chg_now <= 28'h0;
      chg_prev <= 28'h0;
      sample_valid <= 1'b0;
      sample_armed <= 1'b0;
    end else begin
      ext_now <= ext_pin_i;
      ext_prev <= ext_now;
      chg_now <= change_pin_i;
      chg_prev <= chg_now;
      // Two stages: both samples must hold real pin values before edges count
      sample_armed <= 1'b1;
      sample_valid <= sample_armed;
    end
  end

  // ==========================================================
  // Event detection
  // ==========================================================
  // One sense field per pin, same encoding for all four
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ext_level[i] = sense[SENSE_W*i +: SENSE_W] == SENSE_LOW;
      ext_hit[i] = sample_valid && edge_hit(sense[SENSE_W*i +: SENSE_W], ext_now[i], ext_prev[i]);
    end
  end

  // Pin 15 has no mask bit, so it never joins group 1
  assign chg_enable = {mask_g3, mask_g2, 1'b0, mask_g1, mask_g0};
  assign chg_diff = (chg_now ^ chg_prev) & chg_enable & {28{sample_valid}};
  assign group_hit = {|chg_diff[G3_MSB:G3_LSB], |chg_diff[G2_MSB:G2_LSB],
                      |chg_diff[G1_MSB:G1_LSB], |chg_diff[G0_MSB:G0_LSB]};

  // ==========================================================
  // Flags: set wins over any clear
  // ==========================================================
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (ext_level[i]) begin
        next_ext_flags[i] = 1'b0;
      end else if (ext_hit[i]) begin
        next_ext_flags[i] = 1'b1;
      end else if ((wr_ext_flags && bus_i.wdata[i]) || vec_ack_i[i]) begin
        next_ext_flags[i] = 1'b0;
      end else begin
        next_ext_flags[i] = ext_flags[i];
      end
      if (group_hit[i]) begin
        next_group_flags[i] = 1'b1;
      end else if ((wr_group_flags && bus_i.wdata[i]) || vec_ack_i[4+i]) begin
        next_group_flags[i] = 1'b0;
      end else begin
        next_group_flags[i] = group_flags[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ext_flags <= RESET_EXT_FLAGS[3:0];
      group_flags <= RESET_GROUP_FLAGS[3:0];
    end else begin
      ext_flags <= next_ext_flags;
      group_flags <= next_group_flags;
    end
  end

  // ==========================================================
  // Control registers
  // ==========================================================
  // Only the implemented low bits are stored; the rest read zero
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sense <= RESET_SENSE;
      ext_mask <= RESET_EXT_MASK[3:0];
      group_enable <= RESET_GROUP_ENABLE[3:0];
      mask_g0 <= RESET_CHANGE_MASK;
      mask_g1 <= RESET_CHANGE_MASK[6:0];
      mask_g2 <= RESET_CHANGE_MASK;
      mask_g3 <= RESET_CHANGE_MASK[3:0];
    end else if (bus_i.wr) begin
      if (sel == SEL_SENSE) begin
        sense <= bus_i.wdata;
      end else if (sel == SEL_EXT_MASK) begin
        ext_mask <= bus_i.wdata[3:0];
      end else if (sel == SEL_GROUP_ENABLE) begin
        group_enable <= bus_i.wdata[3:0];
      end else if (sel == SEL_MASK_G0) begin
        mask_g0 <= bus_i.wdata;
      end else if (sel == SEL_MASK_G1) begin
        mask_g1 <= bus_i.wdata[6:0];
      end else if (sel == SEL_MASK_G2) begin
        mask_g2 <= bus_i.wdata;
      end else if (sel == SEL_MASK_G3) begin
        mask_g3 <= bus_i.wdata[3:0];
      end
    end
  end

  // ==========================================================
  // Read path, one cycle after the read strobe
  // ==========================================================
  always_comb begin
    case (sel)
      SEL_GROUP_FLAGS: next_rdata = {4'h0, group_flags};
      SEL_EXT_FLAGS: next_rdata = {4'h0, ext_flags};
      SEL_EXT_MASK: next_rdata = {4'h0, ext_mask};
      SEL_GROUP_ENABLE: next_rdata = {4'h0, group_enable};
      SEL_SENSE: next_rdata = sense;
      SEL_MASK_G0: next_rdata = mask_g0;
      SEL_MASK_G1: next_rdata = {1'b0, mask_g1};
      SEL_MASK_G2: next_rdata = mask_g2;
      SEL_MASK_G3: next_rdata = {4'h0, mask_g3};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.rd) begin
      rdata_o <= next_rdata;
    end
  end

  // ==========================================================
  // Vector requests and wake
  // ==========================================================
  // A low level requests directly, so a level held only briefly may be missed
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_irq_req[i] = global_irq_enable_i && ext_mask[i] &&
                        (ext_level[i] ? ~ext_now[i] : ext_flags[i]);
      next_irq_req[4+i] = global_irq_enable_i && group_enable[i] && group_flags[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_req_o <= 8'h00;
      wake_o <= 1'b0;
    end else begin
      irq_req_o <= next_irq_req;
      // Masked compare of sampled pins, no flag needed, so a sleep controller can act on it
      wake_o <= |(chg_diff) || |(ext_level & ext_mask & ~ext_now);
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  rise_sets_flag_a: assert property (
    sample_valid && sense[1:0] == SENSE_RISE && ext_now[0] && !ext_prev[0]
    |=> ext_flags[0])
    else $error("rising edge on pin 0 did not set its flag");

  fall_sets_flag_a: assert property (
    sample_valid && sense[7:6] == SENSE_FALL && ext_now[3]
    ##1 sense[7:6] == SENSE_FALL && !ext_now[3] |=> ext_flags[3])
    else $error("falling edge on pin 3 did not set its flag");

  level_reads_zero_a: assert property (
    sense[3:2] == SENSE_LOW [*2] |-> ext_flags[1] == 1'b0)
    else $error("flag 1 set while in low-level mode");

  write_one_clear_a: assert property (
    wr_ext_flags && bus_i.wdata[2] && !ext_hit[2] |=> !ext_flags[2])
    else $error("write of one did not clear flag 2");

  write_zero_keep_a: assert property (
    wr_ext_flags && !bus_i.wdata[0] && ext_flags[0] && !vec_ack_i[0] && !ext_level[0]
    |=> ext_flags[0])
    else $error("write of zero cleared flag 0");

  ack_clears_flag_a: assert property (
    vec_ack_i[4] && !group_hit[0] |=> !group_flags[0])
    else $error("vector acknowledge did not clear group 0 flag");

  global_gate_a: assert property (
    !global_irq_enable_i |=> irq_req_o == 8'h00)
    else $error("request raised with global enable clear");

  flag_to_request_a: assert property (
    global_irq_enable_i && ext_mask[1] && ext_flags[1] && !ext_level[1] |=> irq_req_o[1])
    else $error("enabled flag 1 did not request its vector");

  group_change_a: assert property (
    sample_valid && mask_g3[0] && (chg_now[24] != chg_prev[24])
    |=> group_flags[3] ##0 (global_irq_enable_i && group_enable[3]) [*1] |=> irq_req_o[7])
    else $error("enabled pin 24 change did not raise group 3");

  io_alias_read_a: assert property (
    bus_i.rd && bus_i.io_space && bus_i.addr == ADDR_EXT_MASK - IO_ALIAS_OFFSET
    |=> rdata_o == {4'h0, $past(ext_mask)})
    else $error("I/O view of the mask register read wrong");

  upper_zero_a: assert property (
    bus_i.rd && sel == SEL_GROUP_ENABLE |=> rdata_o[7:4] == 4'h0)
    else $error("unused group enable bits read nonzero");

  reset_zero_a: assert property (
    disable iff (1'b0) !rst_b_i |=> ext_mask == 4'h0 && ext_flags == 4'h0 && group_enable == 4'h0)
    else $error("registers not zero after reset");

  rise_flag_c: cover property (ext_hit[0] ##1 ext_flags[0]);
  group_flag_c: cover property (group_hit[2] ##1 group_flags[2] ##[1:20] vec_ack_i[6]);
  level_req_c: cover property (ext_level[0] && irq_req_o[0]);
  clear_race_c: cover property (wr_ext_flags && bus_i.wdata[0] && ext_hit[0]);

endmodule

`default_nettype wire

/* File: dv/epic_far_side.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Far side: pin sources and CPU vector dispatch
// ==========================================================
module epic_far_side
  import epic_pkg::*;
#(
  parameter int ACK_DELAY = 0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ack_en_i,
  input wire logic [3:0] ext_level_i,
  input wire logic [27:0] change_level_i,
  input wire logic [7:0] irq_req_i,
  output logic [3:0] ext_pin_o,
  output logic [27:0] change_pin_o,
  output logic [7:0] vec_ack_o
);
  logic [7:0] served;
  logic [7:0] pend;
  logic [7:0] pick;
  int stall;

  // Idle levels from time zero
  initial begin
    ext_pin_o = 4'hf;
    change_pin_o = 28'h0000000;
    vec_ack_o = 8'h00;
    served = 8'h00;
    stall = 0;
  end

  // Levels move off the sampling edge and stay put until the bench moves them
  always @(negedge clk_i) begin
    ext_pin_o <= ext_level_i;
    change_pin_o <= change_level_i;
  end

  // One vector per cycle, lowest first; a standing level request is taken
  // once only, so the model cannot flood the block with acknowledges
  always @(negedge clk_i) begin
    pend = irq_req_i & ~served;
    pick = pend & (~pend + 8'h01);
    vec_ack_o <= 8'h00;
    if (!rst_b_i) begin
      served <= 8'h00;
      stall <= 0;
    end else if (ack_en_i && pend != 8'h00) begin
      if (stall < ACK_DELAY) begin
        stall <= stall + 1;
      end else begin
        vec_ack_o <= pick;
        served <= (served & irq_req_i) | pick;
        stall <= 0;
      end
    end else begin
      served <= served & irq_req_i;
    end
  end
endmodule

`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb
  import epic_pkg::*;
;
  // ==========================================================
  // Signals
  // ==========================================================
  logic clk_i;
  logic rst_b_i;
  logic gie;
  logic ack_en;
  epic_bus_req_s bus;
  logic [3:0] ext_level;
  logic [3:0] ext_pin;
  logic [27:0] chg_level;
  logic [27:0] chg_pin;
  logic [7:0] vec_ack;
  logic [7:0] rdata;
  logic [7:0] irq_req;
  logic [7:0] ack_seen;
  logic wake;
  logic wake_seen;
  int fail_count = 0;
  int n_compared = 0;
  int grp_pin [4] = '{5, 10, 20, 25};
  logic [7:0] rw_addr [6];
  logic [7:0] rw_exp [6];

  epic_ctrl dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .global_irq_enable_i(gie),
    .vec_ack_i(vec_ack), .ext_pin_i(ext_pin), .change_pin_i(chg_pin),
    .rdata_o(rdata), .irq_req_o(irq_req), .wake_o(wake)
  );

  // Slow dispatcher: two idle cycles before each vector
  epic_far_side #(.ACK_DELAY(2)) far_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ack_en_i(ack_en), .ext_level_i(ext_level),
    .change_level_i(chg_level), .irq_req_i(irq_req), .ext_pin_o(ext_pin),
    .change_pin_o(chg_pin), .vec_ack_o(vec_ack)
  );

  // ==========================================================
  // Clock, watchdog and monitors
  // ==========================================================
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // The sequence needs well under 2000 cycles; 12500 means a hang
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end

  // Acknowledge pulses and change wake pulses last one cycle, so latch them
  always @(posedge clk_i) begin
    ack_seen <= ack_seen | vec_ack;
    if (wake === 1'b1) begin
      wake_seen <= 1'b1;
    end
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Strobe for one edge, then one idle edge so strobes never collide
  task automatic bus_wr(input logic [7:0] a, input logic io, input logic [7:0] d);
    bus.addr = a;
    bus.io_space = io;
    bus.wdata = d;
    bus.wr = 1'b1;
    @(negedge clk_i);
    bus.wr = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic io, input logic [7:0] exp,
                        input string what);
    bus.addr = a;
    bus.io_space = io;
    bus.rd = 1'b1;
    @(negedge clk_i);
    check(rdata, exp, what);
    bus.rd = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic set_ext(input int p, input logic lvl);
    ext_level[p] = lvl;
    wait_cyc(5);
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin : main_seq
    logic [7:0] e;
    logic [7:0] x;
    rst_b_i = 1'b0;
    gie = 1'b0;
    ack_en = 1'b0;
    bus = '0;
    ext_level = 4'hf;
    chg_level = 28'h0000000;
    ack_seen = 8'h00;
    wake_seen = 1'b0;
    rw_addr = '{ADDR_EXT_MASK, ADDR_GROUP_ENABLE, ADDR_MASK_G0, ADDR_MASK_G1,
                ADDR_MASK_G2, ADDR_MASK_G3};
    rw_exp = '{8'h0f, 8'h0f, 8'hff, 8'h7f, 8'hff, 8'h0f};
    repeat (6) @(negedge clk_i);
    rst_b_i = 1'b1;
    wait_cyc(2);
    // Reset values of every register, widths of the writable ones
    rd_chk(ADDR_GROUP_FLAGS, 1'b0, 8'h00, "reset group flags");
    rd_chk(ADDR_EXT_FLAGS, 1'b0, 8'h00, "reset ext flags");
    rd_chk(ADDR_SENSE, 1'b0, 8'h00, "reset sense");
    foreach (rw_addr[i]) begin
      rd_chk(rw_addr[i], 1'b0, 8'h00, "reset value");
      bus_wr(rw_addr[i], 1'b0, 8'hff);
      rd_chk(rw_addr[i], 1'b0, rw_exp[i], "writable bits");
    end
    bus_wr(ADDR_SENSE, 1'b0, 8'ha5);
    rd_chk(ADDR_SENSE, 1'b0, 8'ha5, "sense fields");
    // Both address views, unmapped places
    rd_chk(ADDR_EXT_MASK - IO_ALIAS_OFFSET, 1'b1, 8'h0f, "io view read");
    bus_wr(ADDR_EXT_MASK - IO_ALIAS_OFFSET, 1'b1, 8'h03);
    bus_wr(8'h70, 1'b0, 8'hff);
    rd_chk(ADDR_EXT_MASK, 1'b0, 8'h03, "io view write");
    rd_chk(8'h70, 1'b0, 8'h00, "unmapped read");
    rd_chk(ADDR_EXT_MASK, 1'b1, 8'h00, "io view above alias");
    // Every sense code on every pin, falling then rising
    bus_wr(ADDR_EXT_MASK, 1'b0, 8'h00);
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 4; c++) begin
        e = 8'(1 << p);
        bus_wr(ADDR_SENSE, 1'b0, 8'(c << (2 * p)));
        bus_wr(ADDR_EXT_FLAGS, 1'b0, 8'hff);
        set_ext(p, 1'b0);
        x = (c == 1 || c == 2) ? e : 8'h00;
        rd_chk(ADDR_EXT_FLAGS, 1'b0, x, "fall");
        if (c == 2) begin
          bus_wr(ADDR_EXT_FLAGS, 1'b0, ~e);
          rd_chk(ADDR_EXT_FLAGS, 1'b0, e, "zero write keeps");
          bus_wr(ADDR_EXT_FLAGS, 1'b0, e);
          rd_chk(ADDR_EXT_FLAGS, 1'b0, 8'h00, "one write clears");
        end
        bus_wr(ADDR_EXT_FLAGS, 1'b0, 8'hff);
        set_ext(p, 1'b1);
        x = (c == 1 || c == 3) ? e : 8'h00;
        rd_chk(ADDR_EXT_FLAGS, 1'b0, x, "rise");
      end
    end
    // Two-cycle pulse, then the two gates on the request
    bus_wr(ADDR_SENSE, 1'b0, {6'h00, SENSE_RISE});
    bus_wr(ADDR_EXT_FLAGS, 1'b0, 8'hff);
    ext_level[0] = 1'b0;
    wait_cyc(2);
    set_ext(0, 1'b1);
    rd_chk(ADDR_EXT_FLAGS, 1'b0, 8'h01, "short pulse");
    gie = 1'b1;
    wait_cyc(3);
    check(irq_req, 8'h00, "mask bit off");
    bus_wr(ADDR_EXT_MASK, 1'b0, 8'h01);
    wait_cyc(3);
    check(irq_req, 8'h01, "both gates on");
    gie = 1'b0;
    wait_cyc(3);
    check(irq_req, 8'h00, "global flag off");
    gie = 1'b1;
    ack_en = 1'b1;
    wait_cyc(10);
    rd_chk(ADDR_EXT_FLAGS, 1'b0, 8'h00, "vector clears flag");
    check(irq_req, 8'h00, "request gone");
    // Low level on pin 1
    bus_wr(ADDR_SENSE, 1'b0, 8'h00);
    bus_wr(ADDR_EXT_MASK, 1'b0, 8'h02);
    set_ext(1, 1'b0);
    check(irq_req, 8'h02, "level request");
    rd_chk(ADDR_EXT_FLAGS, 1'b0, 8'h00, "level flag");
    set_ext(1, 1'b1);
    check(irq_req, 8'h00, "level released");
    // Pin-change groups with the global flag off, then a group vector with it on
    bus_wr(ADDR_EXT_MASK, 1'b0, 8'h00);
    gie = 1'b0;
    bus_wr(ADDR_MASK_G0, 1'b0, 8'hf7);
    chg_level = 28'h0008008;
    wait_cyc(5);
    rd_chk(ADDR_GROUP_FLAGS, 1'b0, 8'h00, "masked or ungrouped pin");
    foreach (grp_pin[g]) begin
      chg_level[grp_pin[g]] = ~chg_level[grp_pin[g]];
      wait_cyc(5);
      rd_chk(ADDR_GROUP_FLAGS, 1'b0, 8'(1 << g), "group flag");
      check(irq_req, 8'h00, "group without global flag");
      bus_wr(ADDR_GROUP_FLAGS, 1'b0, 8'hff);
    end
    rd_chk(ADDR_GROUP_FLAGS, 1'b0, 8'h00, "group one write clears");
    wake_seen = 1'b0;
    gie = 1'b1;
    chg_level[20] = ~chg_level[20];
    wait_cyc(12);
    rd_chk(ADDR_GROUP_FLAGS, 1'b0, 8'h00, "group vector clears");
    check({7'h00, wake_seen}, 8'h01, "wake on change");
    check(ack_seen, 8'h43, "vectors taken");
    // Second reset, then an edge mode set at the first edge after release
    rst_b_i = 1'b0;
    wait_cyc(2);
    rst_b_i = 1'b1;
    bus_wr(ADDR_SENSE, 1'b0, {6'h00, SENSE_RISE});
    wait_cyc(3);
    rd_chk(ADDR_EXT_FLAGS, 1'b0, 8'h00, "no edge from reset");
    rd_chk(ADDR_GROUP_ENABLE, 1'b0, 8'h00, "enable after reset");
    rd_chk(ADDR_EXT_MASK, 1'b0, 8'h00, "mask after reset");
    print_verdict();
  end
endmodule

`default_nettype wire
